//--- ssm_top.v
`include "ssm_defines.vh"
module ssm_top #(
    parameter [31:0] HALVE_CYC = `SSM_HALVE_S * `SSM_CLK_HZ,
    parameter [31:0] PWM_WIN   = `SSM_PWM_WIN_US * (`SSM_CLK_HZ / 1000000)
) (
    input  wire        ref_clk,
    input  wire        rstn,
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [15:0] reg_wdata,
    output reg  [15:0] reg_rdata,
    output reg         reg_rvalid,
    input  wire [15:0] speed_x10,
    input  wire [15:0] volt_code,
    input  wire [7:0]  temp_c,
    input  wire [15:0] duty_code,
    input  wire [7:0]  node_addr_pins,
    input  wire        pos_step,
    input  wire        pos_dir,
    input  wire        rotor_blocked,
    input  wire        enc_zero,
    input  wire        move_done,
    input  wire        origin_pin,
    input  wire        pwm_pin,
    input  wire        save_done,
    output reg         save_req,
    output reg  [1:0]  ctrl_mode,
    output wire [9:0]  drive_limit,
    output wire        stall_alarm,
    output wire        limit_halved,
    output wire [1:0]  motor_cmd,
    output wire [14:0] move_target,
    output wire        origin_out,
    output reg  [9:0]  speed_target_rpm
);
    reg  [7:0]  addr_s1_r;
    reg  [7:0]  addr_s2_r;
    reg         org_s1_r;
    reg         org_s2_r;
    reg         pwm_s1_r;
    reg         pwm_s2_r;
    reg  [15:0] speed_r;
    reg  [15:0] volt_r;
    reg  [7:0]  temp_r;
    reg  [15:0] duty_r;
    reg  [15:0] save_r;
    reg  [31:0] pos_r;
    reg  [9:0]  limit_r;
    reg  [15:0] func_r;
    reg         start_r;
    reg         boot_r;
    reg         clr_alarm_r;
    reg  [31:0] win_cnt_r;
    reg  [31:0] high_cnt_r;
    reg  [15:0] rd_nxt;

    wire        wr_save  = reg_wr && (reg_addr == `SSM_REG_SAVE);
    wire        wr_pos_l = reg_wr && (reg_addr == `SSM_REG_POS_LO);
    wire        wr_pos_h = reg_wr && (reg_addr == `SSM_REG_POS_HI);
    wire        wr_stall = reg_wr && (reg_addr == `SSM_REG_STALL);
    wire        wr_func  = reg_wr && (reg_addr == `SSM_REG_FUNC);
    // Window end adds its own sample, so a window of N cycles sees N samples
    wire [31:0] high_fin = high_cnt_r + {31'h0000_0000, pwm_s2_r};

    function [9:0] ssm_duty_to_rpm;
        input [31:0] high;
        input [31:0] win;
        reg   [31:0] pm;
        reg   [31:0] rpm;
        begin
            pm  = (high * `SSM_PERMILLE) / win;
            rpm = 32'h0000_0000;
            if (pm >= {21'h0, `SSM_DUTY_HI_PM})
                rpm = {22'h0, `SSM_RPM_MAX};
            else if (pm > {21'h0, `SSM_DUTY_LO_PM})
                rpm = ((pm - {21'h0, `SSM_DUTY_LO_PM}) * 32'd5) >> 2;
            ssm_duty_to_rpm = rpm[9:0];
        end
    endfunction

    function [15:0] ssm_clamp_speed;
        input [15:0] v;
        begin
            if ($signed(v) > `SSM_SPEED_MAX)
                ssm_clamp_speed = `SSM_SPEED_MAX;
            else if ($signed(v) < -`SSM_SPEED_MAX)
                ssm_clamp_speed = -`SSM_SPEED_MAX;
            else
                ssm_clamp_speed = v;
        end
    endfunction

    // Pins from outside the clock domain pass two flops first
    always @(posedge ref_clk) begin
        if (!rstn) begin
            addr_s1_r <= 8'h00;
            addr_s2_r <= 8'h00;
            org_s1_r  <= 1'b0;
            org_s2_r  <= 1'b0;
            pwm_s1_r  <= 1'b0;
            pwm_s2_r  <= 1'b0;
        end else begin
            addr_s1_r <= node_addr_pins;
            addr_s2_r <= addr_s1_r;
            org_s1_r  <= origin_pin;
            org_s2_r  <= org_s1_r;
            pwm_s1_r  <= pwm_pin;
            pwm_s2_r  <= pwm_s1_r;
        end
    end

    // Readback snapshots; speed, voltage and temperature clamped to their printed ranges, duty passed through
    always @(posedge ref_clk) begin
        if (!rstn) begin
            speed_r <= 16'h0000;
            volt_r  <= 16'h0000;
            temp_r  <= 8'h00;
            duty_r  <= 16'h0000;
        end else begin
            speed_r <= ssm_clamp_speed(speed_x10);
            volt_r  <= (volt_code > `SSM_VOLT_MAX) ? `SSM_VOLT_MAX : volt_code;
            temp_r  <= (temp_c > `SSM_TEMP_MAX) ? `SSM_TEMP_MAX : temp_c;
            duty_r  <= duty_code;
        end
    end

    // Save flag: completion wins over a same-cycle clearing write
    always @(posedge ref_clk) begin
        if (!rstn) begin
            save_r   <= `SSM_SAVE_NONE;
            save_req <= 1'b0;
        end else begin
            save_req <= wr_save && (reg_wdata == `SSM_SAVE_BUSY) &&
                        (save_r != `SSM_SAVE_BUSY);
            if (save_done && (save_r == `SSM_SAVE_BUSY || wr_save))
                save_r <= `SSM_SAVE_DONE;
            else if (wr_save && reg_wdata == `SSM_SAVE_BUSY)
                save_r <= `SSM_SAVE_BUSY;
            else if (wr_save && reg_wdata == `SSM_SAVE_NONE)
                save_r <= `SSM_SAVE_NONE;
        end
    end

    // Position: a host load takes priority over a tracked step
    always @(posedge ref_clk) begin
        if (!rstn) begin
            pos_r <= 32'h0000_0000;
        end else if (wr_pos_l) begin
            pos_r[15:0] <= reg_wdata;
        end else if (wr_pos_h) begin
            pos_r[31:16] <= reg_wdata;
        end else if (pos_step) begin
            pos_r <= pos_dir ? pos_r - 32'h1 : pos_r + 32'h1;
        end
    end

    // Limit, function select and start of automatic sequences
    always @(posedge ref_clk) begin
        if (!rstn) begin
            limit_r     <= 10'h000;
            func_r      <= `SSM_FN_PULSE;
            start_r     <= 1'b0;
            boot_r      <= 1'b1;
            clr_alarm_r <= 1'b0;
        end else begin
            clr_alarm_r <= wr_stall;
            if (wr_stall)
                limit_r <= (reg_wdata > {6'h00, `SSM_STALL_MAX}) ?
                           `SSM_STALL_MAX : reg_wdata[9:0];
            if (wr_func)
                func_r <= reg_wdata;
            // Sequences run once after power-up and again on each write to the function register
            start_r <= boot_r || wr_func;
            boot_r  <= 1'b0;
        end
    end

    always @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl_mode <= `SSM_MODE_PULSE;
        end else begin
            case (func_r)
                `SSM_FN_PULSE:  ctrl_mode <= `SSM_MODE_PULSE;
                `SSM_FN_ZOUT:   ctrl_mode <= `SSM_MODE_PULSE;
                `SSM_FN_FOLLOW: ctrl_mode <= `SSM_MODE_FOLLOW;
                `SSM_FN_SPEED:  ctrl_mode <= `SSM_MODE_SPEED;
                `SSM_FN_HOME36, `SSM_FN_HOMEZERO, `SSM_FN_HOMEEN:
                    ctrl_mode <= `SSM_MODE_AUTO;
                default: begin
                    if (func_r >= `SSM_FN_ANGLE_MIN && func_r <= `SSM_FN_ANGLE_MAX)
                        ctrl_mode <= `SSM_MODE_AUTO;
                    else
                        ctrl_mode <= `SSM_MODE_PULSE;
                end
            endcase
        end
    end

    // Duty measured over a fixed window; a window trades latency for resolution
    always @(posedge ref_clk) begin
        if (!rstn) begin
            win_cnt_r        <= 32'h0000_0000;
            high_cnt_r       <= 32'h0000_0000;
            speed_target_rpm <= 10'h000;
        end else if (win_cnt_r >= PWM_WIN - 32'h1) begin
            win_cnt_r  <= 32'h0000_0000;
            high_cnt_r <= 32'h0000_0000;
            speed_target_rpm <= (ctrl_mode == `SSM_MODE_SPEED) ?
                                ssm_duty_to_rpm(high_fin, PWM_WIN) : 10'h000;
        end else begin
            win_cnt_r <= win_cnt_r + 32'h1;
            if (pwm_s2_r)
                high_cnt_r <= high_cnt_r + 32'h1;
        end
    end

    always @* begin
        rd_nxt = 16'h0000;
        case (reg_addr)
            `SSM_REG_SPEED:  rd_nxt = speed_r;
            `SSM_REG_VOLT:   rd_nxt = volt_r;
            `SSM_REG_TEMP:   rd_nxt = {8'h00, temp_r};
            `SSM_REG_DUTY:   rd_nxt = duty_r;
            `SSM_REG_SAVE:   rd_nxt = save_r;
            `SSM_REG_ADDR:   rd_nxt = {8'h00, addr_s2_r};
            `SSM_REG_POS_LO: rd_nxt = pos_r[15:0];
            `SSM_REG_POS_HI: rd_nxt = pos_r[31:16];
            `SSM_REG_STALL:  rd_nxt = {6'h00, limit_r};
            `SSM_REG_FUNC:   rd_nxt = func_r;
            default:         rd_nxt = 16'h0000;
        endcase
    end

    always @(posedge ref_clk) begin
        if (!rstn) begin
            reg_rdata  <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= rd_nxt;
        end
    end

    ssm_stall_guard #(
        .HALVE_CYC (HALVE_CYC)
    ) u_stall (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .limit       (limit_r),
        .blocked     (rotor_blocked),
        .clr_alarm   (clr_alarm_r),
        .drive_limit (drive_limit),
        .stall_alarm (stall_alarm),
        .halved      (limit_halved)
    );

    ssm_homing u_home (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .start       (start_r),
        .func        (func_r),
        .blocked     (rotor_blocked),
        .origin_in   (org_s2_r),
        .enc_zero    (enc_zero),
        .move_done   (move_done),
        .motor_cmd   (motor_cmd),
        .move_target (move_target),
        .origin_out  (origin_out),
        .busy        ()
    );
endmodule

//--- ssm_defines.vh
`ifndef SSM_DEFINES_VH
`define SSM_DEFINES_VH
`define SSM_REG_SPEED      8'h10
`define SSM_REG_VOLT       8'h11
`define SSM_REG_TEMP       8'h12
`define SSM_REG_DUTY       8'h13
`define SSM_REG_SAVE       8'h14
`define SSM_REG_ADDR       8'h15
`define SSM_REG_POS_LO     8'h16
`define SSM_REG_POS_HI     8'h17
`define SSM_REG_STALL      8'h18
`define SSM_REG_FUNC       8'h19
`define SSM_SPEED_MAX      16'sd30000
`define SSM_VOLT_MAX       16'h7FFF
`define SSM_TEMP_MAX       8'd100
`define SSM_SAVE_NONE      16'h0000
`define SSM_SAVE_BUSY      16'h0001
`define SSM_SAVE_DONE      16'h0002
`define SSM_STALL_MAX      10'd609
`define SSM_DIGIT_BASE     10'd10
`define SSM_FN_PULSE       16'h0000
`define SSM_FN_HOME36      16'h0001
`define SSM_FN_FOLLOW      16'h0002
`define SSM_FN_SPEED       16'h0003
`define SSM_FN_HOMEZERO    16'h0004
`define SSM_FN_ZOUT        16'h0005
`define SSM_FN_HOMEEN      16'h0008
`define SSM_FN_ANGLE_MIN   16'h000A
`define SSM_FN_ANGLE_MAX   16'h8000
`define SSM_MODE_PULSE     2'h0
`define SSM_MODE_FOLLOW    2'h1
`define SSM_MODE_SPEED     2'h2
`define SSM_MODE_AUTO      2'h3
`define SSM_CMD_STOP       2'h0
`define SSM_CMD_REV        2'h1
`define SSM_CMD_FWD_REL    2'h2
`define SSM_CMD_GOTO       2'h3
`define SSM_TURN_COUNTS    32768
`define SSM_TURN_DEG       360
`define SSM_HOME_DEG       36
`define SSM_CLK_HZ         40000000
`define SSM_HALVE_S        3
`define SSM_PWM_WIN_US     1000
`define SSM_PERMILLE       1000
`define SSM_DUTY_LO_PM     11'd100
`define SSM_DUTY_HI_PM     11'd900
`define SSM_RPM_MAX        10'd1000
`endif

//--- ssm_stall_guard.v
`include "ssm_defines.vh"
module ssm_stall_guard #(
    parameter [31:0] HALVE_CYC = `SSM_HALVE_S * `SSM_CLK_HZ
) (
    input  wire        ref_clk,
    input  wire        rstn,
    input  wire [9:0]  limit,
    input  wire        blocked,
    input  wire        clr_alarm,
    output reg  [9:0]  drive_limit,
    output reg         stall_alarm,
    output reg         halved
);
    wire        alarm_sel = (limit % `SSM_DIGIT_BASE) != 10'd0;
    reg  [31:0] blk_cnt_r;

    always @(posedge ref_clk) begin
        if (!rstn) begin
            blk_cnt_r   <= 32'h0000_0000;
            stall_alarm <= 1'b0;
            halved      <= 1'b0;
            drive_limit <= 10'h000;
        end else begin
            // Alarm is sticky; a new event beats the clearing write
            if (blocked && alarm_sel)
                stall_alarm <= 1'b1;
            else if (clr_alarm)
                stall_alarm <= 1'b0;
            if (!blocked || alarm_sel) begin
                blk_cnt_r <= 32'h0000_0000;
                halved    <= 1'b0;
            end else if (blk_cnt_r >= HALVE_CYC - 32'h1) begin
                halved <= 1'b1;
            end else begin
                blk_cnt_r <= blk_cnt_r + 32'h1;
            end
            drive_limit <= halved ? (limit >> 1) : limit;
        end
    end
endmodule

//--- ssm_homing.v
`include "ssm_defines.vh"
module ssm_homing (
    input  wire        ref_clk,
    input  wire        rstn,
    input  wire        start,
    input  wire [15:0] func,
    input  wire        blocked,
    input  wire        origin_in,
    input  wire        enc_zero,
    input  wire        move_done,
    output reg  [1:0]  motor_cmd,
    output reg  [14:0] move_target,
    output reg         origin_out,
    output wire        busy
);
    localparam [2:0] S_IDLE = 3'h0, S_REV_STOP = 3'h1, S_MOVE = 3'h2, S_Z_WAIT = 3'h3,
                     S_Z_HOLD = 3'h4, S_REV_ORG = 3'h5, S_ORG_LEAVE = 3'h6;
    localparam integer HOME_CNT_I = `SSM_HOME_DEG * `SSM_TURN_COUNTS / `SSM_TURN_DEG;
    localparam [14:0]  HOME_CNT   = HOME_CNT_I[14:0];
    reg [2:0] st_r;
    assign busy = (st_r != S_IDLE);

    always @(posedge ref_clk) begin
        if (!rstn) begin
            st_r        <= S_IDLE;
            motor_cmd   <= `SSM_CMD_STOP;
            move_target <= 15'h0000;
            origin_out  <= 1'b0;
        end else if (start) begin
            origin_out <= 1'b0;
            motor_cmd  <= `SSM_CMD_STOP;
            if (func == `SSM_FN_HOME36 || func == `SSM_FN_HOMEZERO) begin
                st_r      <= S_REV_STOP;
                motor_cmd <= `SSM_CMD_REV;
            end else if (func == `SSM_FN_ZOUT) begin
                st_r <= S_Z_WAIT;
            end else if (func == `SSM_FN_HOMEEN) begin
                st_r      <= S_REV_ORG;
                motor_cmd <= `SSM_CMD_REV;
            end else if (func >= `SSM_FN_ANGLE_MIN && func <= `SSM_FN_ANGLE_MAX) begin
                st_r        <= S_MOVE;
                motor_cmd   <= `SSM_CMD_GOTO;
                move_target <= func[14:0];
            end else begin
                st_r <= S_IDLE;
            end
        end else begin
            case (st_r)
                S_REV_STOP: if (blocked) begin
                    st_r <= S_MOVE;
                    if (func == `SSM_FN_HOME36) begin
                        motor_cmd   <= `SSM_CMD_FWD_REL;
                        move_target <= HOME_CNT;
                    end else begin
                        motor_cmd   <= `SSM_CMD_GOTO;
                        move_target <= 15'h0000;
                    end
                end
                S_MOVE: if (move_done) begin
                    st_r      <= S_IDLE;
                    motor_cmd <= `SSM_CMD_STOP;
                end
                // External pulses keep moving the rotor in both Z states
                S_Z_WAIT: if (blocked) begin
                    st_r       <= S_Z_HOLD;
                    origin_out <= 1'b1;
                end
                S_Z_HOLD: if (enc_zero) begin
                    st_r       <= S_IDLE;
                    origin_out <= 1'b0;
                end
                S_REV_ORG: if (origin_in) st_r <= S_ORG_LEAVE;
                S_ORG_LEAVE: if (!origin_in) begin
                    st_r      <= S_IDLE;
                    motor_cmd <= `SSM_CMD_STOP;
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end
endmodule

//--- ssm_far_model.sv
module ssm_far_model #(
    parameter logic [3:0] DLY = 4'h5
) (
    input  logic       ref_clk,
    input  logic       rstn,
    input  logic       save_req,
    input  logic [1:0] motor_cmd,
    input  logic       origin_out,
    output logic       save_done,
    output logic       move_done,
    output logic       pos_step,
    output logic       pos_dir
);
    logic [3:0] sv_cnt_r;
    logic [3:0] mv_cnt_r;
    logic [1:0] cmd_prev_r;
    logic [1:0] stp_r;
    assign pos_dir = 1'b0;
    // Answers come DLY+1 cycles after the request, so the busy states are seen from outside
    always @(posedge ref_clk) begin
        if (!rstn) begin
            sv_cnt_r <= 4'h0;
            mv_cnt_r <= 4'h0;
            cmd_prev_r <= 2'h0;
            stp_r <= 2'h0;
            save_done <= 1'b0;
            move_done <= 1'b0;
            pos_step <= 1'b0;
        end else begin
            save_done <= (sv_cnt_r == 4'h1);
            sv_cnt_r <= save_req ? DLY : (sv_cnt_r != 4'h0) ? sv_cnt_r - 4'h1 : 4'h0;
            move_done <= (mv_cnt_r == 4'h1);
            cmd_prev_r <= motor_cmd;
            if (motor_cmd[1] && !cmd_prev_r[1]) begin
                mv_cnt_r <= DLY;
            end else if (mv_cnt_r != 4'h0) begin
                mv_cnt_r <= mv_cnt_r - 4'h1;
            end
            stp_r <= stp_r + 2'h1;
            pos_step <= origin_out && (stp_r == 2'h0);
        end
    end
endmodule

//--- ssm_props.sv
module ssm_props (
    input logic        ref_clk,
    input logic        rstn,
    input logic [7:0]  reg_addr,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [15:0] reg_wdata,
    input logic [15:0] reg_rdata,
    input logic        reg_rvalid,
    input logic [15:0] speed_x10,
    input logic [15:0] volt_code,
    input logic [7:0]  temp_c,
    input logic        rotor_blocked,
    input logic        enc_zero,
    input logic        save_req,
    input logic [1:0]  ctrl_mode,
    input logic [9:0]  drive_limit,
    input logic        stall_alarm,
    input logic        limit_halved,
    input logic [1:0]  motor_cmd,
    input logic [14:0] move_target,
    input logic        origin_out
);
    logic [15:0] spd_exp;
    logic [15:0] vol_exp;
    logic [15:0] tmp_exp;
    always_comb begin
        spd_exp = speed_x10;
        if ($signed(speed_x10) > $signed(16'h7530)) spd_exp = 16'h7530;
        if ($signed(speed_x10) < $signed(16'h8AD0)) spd_exp = 16'h8AD0;
        vol_exp = volt_code[15] ? 16'h7FFF : volt_code;
        tmp_exp = (temp_c > 8'h64) ? 16'h0064 : {8'h00, temp_c};
    end
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_speed_read: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata == $past(spd_exp, 2))
        else $error("speed readback wrong");
    a_volt_read: assert property (reg_rd && reg_addr == 8'h11 |=> reg_rdata == $past(vol_exp, 2))
        else $error("voltage readback wrong");
    a_temp_read: assert property (reg_rd && reg_addr == 8'h12 |=> reg_rdata == $past(tmp_exp, 2))
        else $error("temperature readback wrong");
    a_save_pulse: assert property (reg_wr && reg_addr == 8'h14 && reg_wdata == 16'h0001
        |=> save_req ##1 !save_req) else $error("save request not pulsed");
    a_alarm_raise: assert property (rotor_blocked && !limit_halved && drive_limit % 10 != 0
        && !reg_wr && !$past(reg_wr) && !$past(reg_wr, 2) |=> stall_alarm)
        else $error("stall alarm missing");
    a_limit_halve: assert property ($rose(limit_halved) |=> drive_limit == $past(drive_limit) >> 1)
        else $error("limit not halved");
    a_limit_cap: assert property (drive_limit <= 10'h261)
        else $error("drive limit above cap");
    a_origin_drop: assert property ($fell(origin_out) |-> $past(enc_zero))
        else $error("origin output fell without encoder zero");
    a_home_start: assert property (reg_wr && reg_addr == 8'h19 && reg_wdata == 16'h0001
        |-> ##2 motor_cmd == 2'h1 && ctrl_mode == 2'h3) else $error("homing did not reverse");
    a_goto_angle: assert property (reg_wr && reg_addr == 8'h19 && reg_wdata >= 16'h000A
        && reg_wdata <= 16'h8000 |-> ##2 motor_cmd == 2'h3 && move_target == $past(reg_wdata[14:0], 2))
        else $error("angle move wrong");
    c_halved: cover property ($rose(limit_halved));
    c_origin: cover property ($fell(origin_out));
    c_goto: cover property (motor_cmd == 2'h3);
endmodule

//--- tb.sv
`include "ssm_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk, rstn, reg_wr, reg_rd, reg_rvalid, rotor_blocked, enc_zero;
    logic        pos_step, pos_dir, move_done, origin_pin, pwm_pin, save_done, save_req;
    logic        stall_alarm, limit_halved, origin_out, pwm_en;
    logic [7:0]  reg_addr, temp_c, node_addr_pins;
    logic [15:0] reg_wdata, reg_rdata, speed_x10, volt_code, duty_code;
    logic [1:0]  ctrl_mode, motor_cmd;
    logic [9:0]  drive_limit, speed_target_rpm;
    logic [14:0] move_target;
    int          err_count, n_checks, pwm_cnt;
    ssm_top #(.HALVE_CYC(32'd20), .PWM_WIN(32'd100)) u_dut (.ref_clk, .rstn, .reg_addr,
        .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .speed_x10, .volt_code, .temp_c,
        .duty_code, .node_addr_pins, .pos_step, .pos_dir, .rotor_blocked, .enc_zero,
        .move_done, .origin_pin, .pwm_pin, .save_done, .save_req, .ctrl_mode, .drive_limit,
        .stall_alarm, .limit_halved, .motor_cmd, .move_target, .origin_out,
        .speed_target_rpm);
    ssm_far_model #(.DLY(4'h5)) u_far (.ref_clk, .rstn, .save_req, .motor_cmd, .origin_out,
        .save_done, .move_done, .pos_step, .pos_dir);
    always #12.5 ref_clk = ~ref_clk;
    // Period equals the measuring window, so every window sees the same high count
    always begin
        @(posedge ref_clk);
        #2;
        pwm_cnt = (pwm_cnt + 1) % 100;
        pwm_pin = pwm_en && pwm_cnt < 50;
    end
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
    endtask
    task rchk(input logic [7:0] a, input logic [15:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        chk("rvalid", 16'h0001, {15'h0000, reg_rvalid});
        chk($sformatf("reg %h", a), e, reg_rdata);
        // One idle edge drops the strobe so back-to-back reads each raise it again
        tick(1);
    endtask
    task give_verdict;
        if (err_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #(25 * 6000);
        err_count++;
        give_verdict;
    end
    initial begin
        logic [15:0] fn[4];
        logic [14:0] tg[4];
        ref_clk = 0; rstn = 0; reg_wr = 0; reg_rd = 0; reg_addr = 8'h00; reg_wdata = 16'h0000;
        speed_x10 = 16'h7918; volt_code = 16'h8000; temp_c = 8'h78; duty_code = 16'h8000;
        node_addr_pins = 8'hA5; rotor_blocked = 0; enc_zero = 0; origin_pin = 0;
        pwm_en = 0; pwm_pin = 0; pwm_cnt = 0; err_count = 0; n_checks = 0;
        tick(2);
        rstn = 1;
        tick(3);
        rchk(`SSM_REG_SPEED, 16'h7530);
        rchk(`SSM_REG_VOLT, 16'h7FFF);
        rchk(`SSM_REG_TEMP, 16'h0064);
        rchk(`SSM_REG_DUTY, 16'h8000);
        wr(`SSM_REG_ADDR, 16'h00FF);
        rchk(`SSM_REG_ADDR, 16'h00A5);
        speed_x10 = 16'h8000; volt_code = 16'h1234; temp_c = 8'h19;
        wr(`SSM_REG_SPEED, 16'h0000);
        rchk(`SSM_REG_SPEED, 16'h8AD0);
        rchk(`SSM_REG_VOLT, 16'h1234);
        rchk(`SSM_REG_TEMP, 16'h0019);
        rchk(8'h1A, 16'h0000);
        wr(`SSM_REG_POS_LO, 16'h1234);
        tick(1);
        wr(`SSM_REG_POS_HI, 16'hFEDC);
        rchk(`SSM_REG_POS_LO, 16'h1234);
        rchk(`SSM_REG_POS_HI, 16'hFEDC);
        wr(`SSM_REG_SAVE, 16'h0001);
        rchk(`SSM_REG_SAVE, `SSM_SAVE_BUSY);
        tick(10);
        rchk(`SSM_REG_SAVE, `SSM_SAVE_DONE);
        wr(`SSM_REG_SAVE, 16'h0000);
        rchk(`SSM_REG_SAVE, `SSM_SAVE_NONE);
        wr(`SSM_REG_STALL, 16'h02BC);
        rchk(`SSM_REG_STALL, 16'h0261);
        chk("drive_limit", 16'h0261, {6'h00, drive_limit});
        wr(`SSM_REG_STALL, 16'h0131);
        rotor_blocked = 1;
        tick(4);
        rotor_blocked = 0;
        tick(1);
        chk("stall_alarm", 16'h0001, {15'h0000, stall_alarm});
        wr(`SSM_REG_STALL, 16'h012C);
        tick(3);
        chk("stall_alarm", 16'h0000, {15'h0000, stall_alarm});
        rotor_blocked = 1;
        tick(25);
        rotor_blocked = 0;
        chk("limit_halved", 16'h0001, {15'h0000, limit_halved});
        chk("drive_limit", 16'h0096, {6'h00, drive_limit});
        chk("stall_alarm", 16'h0000, {15'h0000, stall_alarm});
        fn = '{`SSM_FN_PULSE, `SSM_FN_FOLLOW, `SSM_FN_SPEED, 16'h0000};
        for (int i = 0; i < 3; i++) begin
            wr(`SSM_REG_FUNC, fn[i]);
            tick(2);
            chk("ctrl_mode", i, {14'h0000, ctrl_mode});
        end
        pwm_en = 1;
        tick(350);
        chk("speed_target_rpm", 16'h01F4, {6'h00, speed_target_rpm});
        pwm_en = 0;
        fn = '{`SSM_FN_HOME36, `SSM_FN_HOMEZERO, 16'h3039, `SSM_FN_ANGLE_MAX};
        tg = '{15'h0CCC, 15'h0000, 15'h3039, 15'h0000};
        for (int i = 0; i < 4; i++) begin
            wr(`SSM_REG_FUNC, fn[i]);
            tick(2);
            if (i < 2) begin
                chk("motor_cmd", 16'h0001, {14'h0000, motor_cmd});
                rotor_blocked = 1;
                tick(1);
                rotor_blocked = 0;
                tick(1);
            end
            chk("motor_cmd", i == 0 ? 16'h0002 : 16'h0003, {14'h0000, motor_cmd});
            chk("move_target", {1'b0, tg[i]}, {1'b0, move_target});
            tick(12);
            if (i < 2) chk("motor_cmd", 16'h0000, {14'h0000, motor_cmd});
        end
        wr(`SSM_REG_FUNC, `SSM_FN_ZOUT);
        tick(2);
        rotor_blocked = 1;
        tick(1);
        rotor_blocked = 0;
        tick(1);
        chk("origin_out", 16'h0001, {15'h0000, origin_out});
        tick(8);
        chk("origin_out", 16'h0001, {15'h0000, origin_out});
        enc_zero = 1;
        tick(1);
        enc_zero = 0;
        tick(1);
        chk("origin_out", 16'h0000, {15'h0000, origin_out});
        wr(`SSM_REG_FUNC, `SSM_FN_HOMEEN);
        tick(2);
        chk("motor_cmd", 16'h0001, {14'h0000, motor_cmd});
        origin_pin = 1;
        tick(8);
        chk("motor_cmd", 16'h0001, {14'h0000, motor_cmd});
        origin_pin = 0;
        tick(6);
        chk("motor_cmd", 16'h0000, {14'h0000, motor_cmd});
        give_verdict;
    end
endmodule
bind ssm_top ssm_props u_props (.ref_clk, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .speed_x10, .volt_code, .temp_c, .rotor_blocked, .enc_zero,
    .save_req, .ctrl_mode, .drive_limit, .stall_alarm, .limit_halved, .motor_cmd,
    .move_target, .origin_out);
